// file: logic/bcr_pkg.sv
// constants and carriers for the bridge configuration register bank
package bcr_pkg;
    // register indexes; byte address is four times the index
    localparam logic [9:0]  IDX_INTR_PIN   = 10'h03D;
    localparam logic [9:0]  IDX_BRIDGE_CTL = 10'h03E;
    localparam logic [9:0]  IDX_CAP_HDR    = 10'h040;
    localparam logic [9:0]  IDX_IRQ_STATUS = 10'h100;
    localparam logic [9:0]  IDX_IRQ_MASK   = 10'h101;
    localparam int          ADDR_W         = 12;

    // interrupt pin field
    localparam logic [7:0]  INTR_PIN_RST   = 8'h00;
    localparam logic [7:0]  INTR_PIN_MAX   = 8'h04;

    // bridge control field positions
    localparam int          BC_POISON      = 0;
    localparam int          BC_ERR_FWD     = 1;
    localparam int          BC_LEGACY_IO   = 2;
    localparam int          BC_VIDEO_FWD   = 3;
    localparam int          BC_VIDEO_WIDE  = 4;
    localparam int          BC_SEC_RESET   = 6;
    localparam logic [15:0] BC_RST         = 16'h0000;

    // capability header fields
    localparam logic [7:0]  CAP_ID         = 8'h10;
    localparam logic [7:0]  CAP_NEXT_RST   = 8'hC0;
    localparam logic [3:0]  CAP_VER_RST    = 4'h1;
    localparam logic [3:0]  PORT_TYPE_UP   = 4'h5;
    localparam logic [3:0]  PORT_TYPE_DOWN = 4'h6;
    localparam logic [4:0]  MSI_NUM        = 5'h00;

    // interrupt status bit positions
    localparam int          EV_POISON      = 0;
    localparam int          EV_ERR_FWD     = 1;
    localparam int          EV_SEC_RESET   = 2;
    localparam int          EV_W           = 3;

    // address decode limits
    localparam logic [31:0] IO_LOW_LIMIT   = 32'h0001_0000;
    localparam logic [31:0] VID_MEM_LO     = 32'h000A_0000;
    localparam logic [31:0] VID_MEM_HI     = 32'h000B_FFFF;
    localparam logic [9:0]  VID_IO_A_LO    = 10'h3B0;
    localparam logic [9:0]  VID_IO_A_HI    = 10'h3BB;
    localparam logic [9:0]  VID_IO_B_LO    = 10'h3C0;
    localparam logic [9:0]  VID_IO_B_HI    = 10'h3DF;

    typedef enum logic [1:0] {
        BCR_ERR_COR      = 2'b00,
        BCR_ERR_NONFATAL = 2'b01,
        BCR_ERR_FATAL    = 2'b10
    } bcr_err_e;

    typedef struct packed {
        logic     valid;
        bcr_err_e kind;
    } bcr_err_msg_s;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        in_window;
        logic [31:0] addr;
    } bcr_addr_req_s;

    typedef struct packed {
        logic valid;
        logic fwd_down;
        logic fwd_up;
        logic video_hit;
    } bcr_route_s;
endpackage : bcr_pkg

// file: logic/bcr_route_decode.sv
// address routing decode for the legacy io and video windows
`timescale 1ns/1ps
module bcr_route_decode
    import bcr_pkg::*;
(
    // request
    input  wire bcr_pkg::bcr_addr_req_s req,
    // controls from bridge control
    input  wire logic                   legacy_io_route_enable,
    input  wire logic                   video_compat_forward_enable,
    input  wire logic                   video_wide_decode_enable,
    // result
    output      bcr_pkg::bcr_route_s    route
);
    logic isa_hit;
    logic vid_io;
    logic vid_mem;
    logic wide_ok;

    always_comb begin
        // top 768 bytes of each 1 KB block inside the low 64 KB
        isa_hit = req.is_io && (req.addr < IO_LOW_LIMIT) && (req.addr[9:8] != 2'b00);
        // 10-bit decode aliases; 16-bit decode needs upper bits clear
        wide_ok = !video_wide_decode_enable || (req.addr[31:10] == 22'h0);
        vid_io  = req.is_io && wide_ok &&
                  (((req.addr[9:0] >= VID_IO_A_LO) && (req.addr[9:0] <= VID_IO_A_HI)) ||
                   ((req.addr[9:0] >= VID_IO_B_LO) && (req.addr[9:0] <= VID_IO_B_HI)));
        vid_mem = !req.is_io && (req.addr >= VID_MEM_LO) && (req.addr <= VID_MEM_HI);
        route.valid     = req.valid;
        route.video_hit = req.valid && video_compat_forward_enable && (vid_io || vid_mem);
        route.fwd_up    = req.valid && req.in_window && legacy_io_route_enable && isa_hit;
        route.fwd_down  = req.valid && ((req.in_window && !(legacy_io_route_enable && isa_hit)) ||
                          route.video_hit);
    end
endmodule : bcr_route_decode

// file: logic/bcr_regs.sv
// bridge control and express capability header register bank
//
// What this block does
// - interrupt pin accepts only values zero to four
// - interrupt pin resets to none
// - bit 0 enables poisoned tlp reporting
// - bit 1 gates secondary error message forwarding
// - forwarding also needs command or device enable
// - bit 2 sends low isa io upstream
// - bit 3 forwards video compatible addresses
// - bit 4 selects 16-bit video decode
// - bit 6 drives secondary bus reset, or upstream_sec_reset on upstream
// - capability id reads 0x10
// - next pointer defaults to 0xC0
// - version defaults to one
// - port type reads five or six
// - slot bit kept zero on upstream
// - msi number reads zero
// - tcs support defaults one, zero in 1.1
`timescale 1ns/1ps
module bcr_regs
    import bcr_pkg::*;
#(
    parameter int AW = bcr_pkg::ADDR_W
)
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // straps, sampled after reset release
    input  wire logic                  strap_upstream,
    input  wire logic                  strap_mode_11,
    // register port
    input  wire logic [AW-1:0]         reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output      logic [31:0]           reg_rdata,
    // error enables held elsewhere in config space
    input  wire logic                  cmd_err_report_en,
    input  wire logic                  devctl_err_report_en,
    // secondary side events
    input  wire logic                  sec_poison_seen,
    input  wire bcr_pkg::bcr_err_msg_s sec_err_msg,
    // primary side results
    output      logic                  poison_report,
    output      bcr_pkg::bcr_err_msg_s pri_err_msg,
    // address routing
    input  wire bcr_pkg::bcr_addr_req_s route_req,
    output      bcr_pkg::bcr_route_s   route_out,
    // resets and interrupt selection
    output      logic                  sec_bus_reset,
    output      logic                  upstream_sec_reset,
    output      logic [7:0]            intx_select,
    output      logic                  irq
);
    import bcr_pkg::*;

    // parameter check
    // index decode reads address bits 11:2
    if (AW < 12) begin : g_aw_check
        $error("bcr_regs: AW too small for register map");
    end

    logic [7:0]        legacy_interrupt_pin;
    logic [15:0]       bridge_control;
    logic [7:0]        next_capability_pointer;
    logic [3:0]        capability_version;
    logic              slot_implemented;
    logic              traffic_class_routing_support;
    logic              port_upstream;
    logic              straps_taken;
    logic [EV_W-1:0]   irq_status;
    logic [EV_W-1:0]   irq_mask;
    logic [EV_W-1:0]   ev_set;
    logic              sec_reset_prev;
    logic [31:0]       next_rdata;
    logic [31:0]       express_capability_header;
    logic [9:0]        idx;
    logic              wr_ok;
    logic              rd_ok;
    bcr_route_s        route_now;

    function automatic logic hit(input logic [AW-1:0] a, input logic [9:0] i);
        hit = (a[1:0] == 2'b00) && (a[AW-1:2] == (AW-2)'(i));
    endfunction : hit

    assign idx   = reg_addr[11:2];
    assign wr_ok = reg_wr && (reg_addr[1:0] == 2'b00);
    assign rd_ok = reg_rd && (reg_addr[1:0] == 2'b00);

    // straps are caught once, on the first edge after release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            straps_taken  <= 1'b0;
            port_upstream <= 1'b0;
        end else if (!straps_taken) begin
            straps_taken  <= 1'b1;
            port_upstream <= strap_upstream;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            legacy_interrupt_pin <= INTR_PIN_RST;
        end else if (wr_ok && hit(reg_addr, IDX_INTR_PIN) && (reg_wdata[7:0] <= INTR_PIN_MAX)) begin
            legacy_interrupt_pin <= reg_wdata[7:0];
        end
    end

    // only defined control bits are stored
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bridge_control <= BC_RST;
        end else if (wr_ok && hit(reg_addr, IDX_BRIDGE_CTL)) begin
            bridge_control[BC_POISON]     <= reg_wdata[BC_POISON];
            bridge_control[BC_ERR_FWD]    <= reg_wdata[BC_ERR_FWD];
            bridge_control[BC_LEGACY_IO]  <= reg_wdata[BC_LEGACY_IO];
            bridge_control[BC_VIDEO_FWD]  <= reg_wdata[BC_VIDEO_FWD];
            bridge_control[BC_VIDEO_WIDE] <= reg_wdata[BC_VIDEO_WIDE];
            bridge_control[BC_SEC_RESET]  <= reg_wdata[BC_SEC_RESET];
        end
    end

    // capability header writable fields
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            next_capability_pointer <= CAP_NEXT_RST;
            capability_version      <= CAP_VER_RST;
            slot_implemented        <= 1'b0;
        end else if (wr_ok && hit(reg_addr, IDX_CAP_HDR)) begin
            next_capability_pointer <= reg_wdata[15:8];
            capability_version      <= reg_wdata[19:16];
            // slot stays zero on the upstream port
            slot_implemented        <= reg_wdata[24] && straps_taken && !port_upstream;
        end
    end

    // tcs default follows the mode strap, loaded once
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            traffic_class_routing_support <= 1'b1;
        end else if (!straps_taken) begin
            traffic_class_routing_support <= !strap_mode_11;
        end else if (wr_ok && hit(reg_addr, IDX_CAP_HDR)) begin
            traffic_class_routing_support <= reg_wdata[30];
        end
    end

    always_comb begin
        express_capability_header        = 32'h0000_0000;
        express_capability_header[7:0]   = CAP_ID;
        express_capability_header[15:8]  = next_capability_pointer;
        express_capability_header[19:16] = capability_version;
        express_capability_header[23:20] = port_upstream ? PORT_TYPE_UP : PORT_TYPE_DOWN;
        express_capability_header[24]    = slot_implemented;
        express_capability_header[29:25] = MSI_NUM;
        express_capability_header[30]    = traffic_class_routing_support;
    end

    // read mux; unmapped and misaligned reads give zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        // upper address bits must be clear, as for writes
        if (rd_ok && hit(reg_addr, idx)) begin
            unique case (idx)
                IDX_INTR_PIN:   next_rdata = {24'h00_0000, legacy_interrupt_pin};
                IDX_BRIDGE_CTL: next_rdata = {16'h0000, bridge_control};
                IDX_CAP_HDR:    next_rdata = express_capability_header;
                IDX_IRQ_STATUS: next_rdata = {{(32-EV_W){1'b0}}, irq_status};
                IDX_IRQ_MASK:   next_rdata = {{(32-EV_W){1'b0}}, irq_mask};
                default:        next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // poisoned tlps reported only when enabled
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            poison_report <= 1'b0;
        end else begin
            poison_report <= sec_poison_seen && bridge_control[BC_POISON];
        end
    end

    // primary side reporting enable also needed
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pri_err_msg <= '0;
        end else begin
            pri_err_msg.valid <= sec_err_msg.valid && bridge_control[BC_ERR_FWD] &&
                                 (cmd_err_report_en || devctl_err_report_en);
            pri_err_msg.kind  <= sec_err_msg.kind;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sec_bus_reset      <= 1'b0;
            upstream_sec_reset <= 1'b0;
            sec_reset_prev     <= 1'b0;
        end else begin
            sec_bus_reset      <= bridge_control[BC_SEC_RESET] && !port_upstream;
            upstream_sec_reset <= bridge_control[BC_SEC_RESET] && port_upstream;
            sec_reset_prev     <= bridge_control[BC_SEC_RESET];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            intx_select <= INTR_PIN_RST;
        end else begin
            intx_select <= legacy_interrupt_pin;
        end
    end

    bcr_route_decode u_route (
        .req                         (route_req),
        .legacy_io_route_enable      (bridge_control[BC_LEGACY_IO]),
        .video_compat_forward_enable (bridge_control[BC_VIDEO_FWD]),
        .video_wide_decode_enable    (bridge_control[BC_VIDEO_WIDE]),
        .route                       (route_now)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            route_out <= '0;
        end else begin
            route_out <= route_now;
        end
    end

    // sticky events; a set in the clearing read wins
    always_comb begin
        ev_set               = '0;
        ev_set[EV_POISON]    = sec_poison_seen && bridge_control[BC_POISON];
        ev_set[EV_ERR_FWD]   = sec_err_msg.valid && bridge_control[BC_ERR_FWD] &&
                               (cmd_err_report_en || devctl_err_report_en);
        ev_set[EV_SEC_RESET] = bridge_control[BC_SEC_RESET] && !sec_reset_prev;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_status <= '0;
        end else if (rd_ok && hit(reg_addr, IDX_IRQ_STATUS)) begin
            irq_status <= ev_set;
        end else begin
            irq_status <= irq_status | ev_set;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= '0;
        end else if (wr_ok && hit(reg_addr, IDX_IRQ_MASK)) begin
            irq_mask <= reg_wdata[EV_W-1:0];
        end
    end

    // level output; lags status by one cycle, a flop by design
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule : bcr_regs

// file: verification/bcr_regs_monitor.sv
// assertion checker for the bridge configuration register bank
`timescale 1ns/1ps
module bcr_regs_monitor
    import bcr_pkg::*;
#(
    parameter int AW = 12
)
(
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   resetn,
    // register port
    input wire logic [AW-1:0]          reg_addr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    // events and results
    input wire logic                   cmd_err_report_en,
    input wire logic                   devctl_err_report_en,
    input wire logic                   sec_poison_seen,
    input wire bcr_pkg::bcr_err_msg_s  sec_err_msg,
    input wire logic                   poison_report,
    input wire bcr_pkg::bcr_err_msg_s  pri_err_msg,
    input wire bcr_pkg::bcr_addr_req_s route_req,
    input wire bcr_pkg::bcr_route_s    route_out,
    input wire logic                   sec_bus_reset,
    input wire logic                   upstream_sec_reset,
    input wire logic [7:0]             intx_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    pin_range_a: assert property (intx_select <= 8'h04)
        else $error("interrupt selection above four");
    poison_cause_a: assert property (poison_report |-> $past(sec_poison_seen))
        else $error("poison report without poisoned input");
    err_kind_a: assert property (pri_err_msg.valid |-> pri_err_msg.kind == $past(sec_err_msg.kind))
        else $error("forwarded error kind differs");
    err_enable_a: assert property (pri_err_msg.valid |-> $past(sec_err_msg.valid) &&
        ($past(cmd_err_report_en) || $past(devctl_err_report_en))) else $error("error forwarded while disabled");
    route_lat_a: assert property (route_out.valid == $past(route_req.valid))
        else $error("route answer not one cycle after request");
    reset_side_a: assert property (!(sec_bus_reset && upstream_sec_reset))
        else $error("both secondary reset outputs high");
    reset_follow_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h0F8 |->
        (sec_bus_reset || upstream_sec_reset) == reg_rdata[6]) else $error("secondary reset differs from control");
    cap_fixed_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h100 |->
        reg_rdata[7:0] == 8'h10 && reg_rdata[29:25] == 5'h00 && !reg_rdata[31]) else $error("cap fixed fields");
    port_type_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h100 |->
        reg_rdata[23:20] inside {4'h5, 4'h6} && !(reg_rdata[23:20] == 4'h5 && reg_rdata[24]))
        else $error("port type or slot bit wrong");
    ctl_reserved_a: assert property ($past(reg_rd) && $past(reg_addr) == 12'h0F8 |->
        reg_rdata[31:7] == 25'h0 && !reg_rdata[5]) else $error("control reserved bits set");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer cycle");
endmodule : bcr_regs_monitor

bind bcr_regs bcr_regs_monitor #(.AW(AW)) i_bcr_regs_monitor (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_err_report_en(cmd_err_report_en),
    .devctl_err_report_en(devctl_err_report_en), .sec_poison_seen(sec_poison_seen), .sec_err_msg(sec_err_msg),
    .poison_report(poison_report), .pri_err_msg(pri_err_msg), .route_req(route_req), .route_out(route_out),
    .sec_bus_reset(sec_bus_reset), .upstream_sec_reset(upstream_sec_reset), .intx_select(intx_select));

// file: verification/testbench.sv
// self-checking bench for the bridge configuration register bank
`timescale 1ns/1ps
module testbench;
    import bcr_pkg::*;
    logic          clk_sys = 1'b0;
    logic          resetn = 1'b0;
    logic          strap_upstream = 1'b0;
    logic          strap_mode_11 = 1'b0;
    logic [11:0]   reg_addr = 12'h000;
    logic [31:0]   reg_wdata = 32'h0;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [31:0]   reg_rdata;
    logic          cmd_err_report_en = 1'b0;
    logic          devctl_err_report_en = 1'b0;
    logic          sec_poison_seen = 1'b0;
    bcr_err_msg_s  sec_err_msg = '0;
    logic          poison_report;
    bcr_err_msg_s  pri_err_msg;
    bcr_addr_req_s route_req = '0;
    bcr_route_s    route_out;
    logic          sec_bus_reset;
    logic          upstream_sec_reset;
    logic [7:0]    intx_select;
    logic          irq;
    logic          rd_d = 1'b0;
    logic [31:0]   exp_q [3][$];
    int            n_errors = 0;
    int            checks_done = 0;
    int            cycles = 0;
    // control, io, in window, address, expected {valid, down, up, video}
    logic [45:0]   rt [8] = '{
        {8'h04, 2'b11, 32'h0000_0100, 4'hA}, {8'h04, 2'b11, 32'h0000_0000, 4'hC},
        {8'h00, 2'b11, 32'h0000_0100, 4'hC}, {8'h04, 2'b11, 32'h0001_0100, 4'hC},
        {8'h08, 2'b10, 32'h0000_13C0, 4'hD}, {8'h18, 2'b10, 32'h0000_13C0, 4'h8},
        {8'h00, 2'b10, 32'h0000_03C0, 4'h8}, {8'h08, 2'b00, 32'h000A_0000, 4'hD}};

    always #2.5 clk_sys = ~clk_sys;

    bcr_regs #(.AW(12)) i_bcr_regs (.clk_sys(clk_sys), .resetn(resetn), .strap_upstream(strap_upstream),
        .strap_mode_11(strap_mode_11), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_err_report_en(cmd_err_report_en),
        .devctl_err_report_en(devctl_err_report_en), .sec_poison_seen(sec_poison_seen),
        .sec_err_msg(sec_err_msg), .poison_report(poison_report), .pri_err_msg(pri_err_msg),
        .route_req(route_req), .route_out(route_out), .sec_bus_reset(sec_bus_reset),
        .upstream_sec_reset(upstream_sec_reset), .intx_select(intx_select), .irq(irq));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        checks_done++;
        if (seen !== expv) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, expv, seen);
        end
    endtask : check

    function automatic logic [31:0] pop(input int i);
        if (exp_q[i].size() == 0)
            return 32'hXXXX_XXXX;
        return exp_q[i].pop_front();
    endfunction : pop

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // expectation queued first, so the watcher always finds it
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q[0].push_back(e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
    endtask : rd

    task automatic ev(input logic p, input bcr_err_msg_s m, input bcr_addr_req_s q);
        @(posedge clk_sys);
        sec_poison_seen <= p;
        sec_err_msg     <= m;
        route_req       <= q;
        @(posedge clk_sys);
        sec_poison_seen <= 1'b0;
        sec_err_msg     <= '0;
        route_req       <= '0;
    endtask : ev

    // watcher: one settle step after each edge, results matched in order
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        cycles <= cycles + 1;
        #1;
        if (rd_d)
            check("reg_rdata", reg_rdata, pop(0));
        if (poison_report === 1'b1 || pri_err_msg.valid === 1'b1)
            check("event_out", {28'h0, poison_report, pri_err_msg}, pop(1));
        if (route_out.valid === 1'b1)
            check("route_out", {28'h0, route_out}, pop(2));
        if (cycles > 5000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        logic        up;
        logic        m11;
        logic [31:0] cap;
        logic [7:0]  bad;
        void'($urandom(22961));
        for (int c = 0; c < 2; c++) begin
            up = (c == 0);
            m11 = (c == 1);
            // reset and straps change on a rising edge, as all stimulus but the error enable clear after the irq check
            @(posedge clk_sys);
            resetn         <= 1'b0;
            strap_upstream <= up;
            strap_mode_11  <= m11;
            repeat (3) @(posedge clk_sys);
            resetn <= 1'b1;
            @(posedge clk_sys);
            cap = {1'b0, !m11, MSI_NUM, 1'b0, up ? PORT_TYPE_UP : PORT_TYPE_DOWN, CAP_VER_RST, CAP_NEXT_RST, CAP_ID};
            #1 check("intx_select", {24'h0, intx_select}, 32'h0);
            rd(12'h0F4, 32'h0);
            rd(12'h0F8, 32'h0);
            rd(12'h100, cap);
            rd(12'h400, 32'h0);
            rd(12'h404, 32'h0);
            rd(12'h200, 32'h0);
            rd(12'h0F5, 32'h0);
            $display("test reset_values done");
            wr(12'h100, 32'hFFFF_FFFF);
            rd(12'h100, {2'b01, MSI_NUM, !up, cap[23:20], 4'hF, 8'hFF, CAP_ID});
            $display("test capability done");
            for (int i = 0; i <= 4; i++) begin
                wr(12'h0F4, 32'(i));
                rd(12'h0F4, 32'(i));
                #1 check("intx_select", {24'h0, intx_select}, 32'(i));
            end
            bad = 8'h05 + 8'($urandom % 251);
            wr(12'h0F4, {24'h0, bad});
            rd(12'h0F4, 32'h4);
            $display("test interrupt_pin done");
            wr(12'h0F8, 32'hFFFF_FFFF);
            rd(12'h0F8, 32'h5F);
            #1 check("sec_bus_reset", {31'h0, sec_bus_reset}, {31'h0, !up});
            check("upstream_sec_reset", {31'h0, upstream_sec_reset}, {31'h0, up});
            check("irq", {31'h0, irq}, 32'h0);
            wr(12'h404, 32'h7);
            @(posedge clk_sys);
            #1 check("irq", {31'h0, irq}, 32'h1);
            rd(12'h400, 32'h4);
            rd(12'h400, 32'h0);
            #1 check("irq", {31'h0, irq}, 32'h0);
            $display("test control_irq done");
            wr(12'h0F8, 32'h3);
            cmd_err_report_en    <= up;
            devctl_err_report_en <= !up;
            exp_q[1].push_back(32'h8);
            ev(1'b1, '0, '0);
            for (int k = 0; k < 3; k++) begin
                exp_q[1].push_back(32'(4 + k));
                ev(1'b0, bcr_err_msg_s'({1'b1, 2'(k)}), '0);
            end
            @(posedge clk_sys);
            #1 check("irq", {31'h0, irq}, 32'h1);
            cmd_err_report_en    <= 1'b0;
            devctl_err_report_en <= 1'b0;
            ev(1'b0, bcr_err_msg_s'(3'h6), '0);
            rd(12'h400, 32'h3);
            wr(12'h0F8, 32'h0);
            cmd_err_report_en <= 1'b1;
            ev(1'b1, bcr_err_msg_s'(3'h5), '0);
            rd(12'h400, 32'h0);
            $display("test events done");
            for (int i = 0; i < 8; i++) begin
                wr(12'h0F8, {24'h0, rt[i][45:38]});
                exp_q[2].push_back({28'h0, rt[i][3:0]});
                ev(1'b0, '0, bcr_addr_req_s'({1'b1, rt[i][37:4]}));
            end
            repeat (2) @(posedge clk_sys);
            #1 check("pending", 32'(exp_q[0].size() + exp_q[1].size() + exp_q[2].size()), 32'h0);
            $display("test routing done");
        end
        test_done();
    end
endmodule : testbench
